// ### hdl/rdpu_defs.vh
// Constants for the ROM read-data patch unit: register window, offsets,
// field positions and reset values.
// Assumes a 32-bit AHB-Lite bus with word-aligned register accesses.
`ifndef RDPU_DEFS_VH
`define RDPU_DEFS_VH

// Number of substitution entries and index width
`define RDPU_ENTRIES 8
`define RDPU_IDX_W 3

// Register window 0x40008400 .. 0x400087FF, decoded on HADDR[31:10]
`define RDPU_WIN_BASE 32'h40008400
`define RDPU_WIN_LAST 32'h400087FF
`define RDPU_WIN_TAG_HI 31
`define RDPU_WIN_TAG_LO 10
`define RDPU_WORD_HI 9
`define RDPU_WORD_LO 2
// Window tag: the base address shifted down by the tag's low bit
`define RDPU_WIN_TAG 22'h100021
// Pair word layout: entry number above, address or data half in bit 0
`define RDPU_PAIR_HI 3
`define RDPU_PAIR_LO 1
`define RDPU_PAIR_DATA_BIT 0

// Word indices inside the window; entry x address at 2x, data at 2x+1
`define RDPU_IDX_PAIR_LAST 8'h0F
`define RDPU_IDX_FLAGS 8'h10
`define RDPU_IDX_DISABLE 8'h11
`define RDPU_IDX_ENABLE 8'h12

// Reset values
`define RDPU_RST_WORD 32'h00000000
`define RDPU_RST_FLAGS 8'h00

// AHB encodings
`define RDPU_HTRANS_SEQ_BIT 1
`define RDPU_HRESP_OKAY 1'h0
`define RDPU_HRESP_ERROR 1'h1

`endif

// ### hdl/rdpu_patch_unit.v
// ROM read-data patch unit: eight address/data entries that replace ROM
// read data, with an AHB-Lite slave for programming.
// Assumes HADDR/HTRANS/HWRITE/HREADY are the shared system AHB signals,
// that the address decoder drives separate selects for the ROM and for
// this register window, and that the ROM controller returns read data
// in the AHB data phase.
// Limitations: HSIZE is not decoded, so narrow writes store a whole word;
// an address write disarms its entry until the matching data word is written;
// the ROM data mux is the only combinational output, to avoid a wait state.
`timescale 1ns/1ps
`default_nettype none
`include "rdpu_defs.vh"

// Summary of operation
// - Eight entries, each a 32-bit match address and 32-bit replacement word.
// - Entry address and data registers sit at consecutive word locations.
// - Writing data after its address sets the entry enable automatically.
// - All eight addresses are compared with the bus address in parallel.
// - An enabled matching entry replaces the ROM read data.
// - Among several matches the highest-numbered entry wins.
// - Writing one to a disable bit clears that entry's enable.
// - Writing one to an enable bit sets that entry's enable again.
// - Substitution applies only to data returned from ROM.
// - All registers are reached as an AHB slave.
// - The register window decodes 0x40008400 to 0x400087FF.
// - Runs on the bus clock; software reprograms entries after power-up.
module rdpu_patch_unit (
  input wire REF_CLK_IN,
  input wire RST_B_IN,
  // Shared AHB address- and data-phase signals
  input wire [31:0] HADDR_IN,
  input wire [1:0] HTRANS_IN,
  input wire HWRITE_IN,
  input wire [2:0] HSIZE_IN,
  input wire [31:0] HWDATA_IN,
  input wire HREADY_IN,
  // Register window slave
  input wire HSEL_REG_IN,
  output reg [31:0] HRDATA_OUT,
  output reg HREADYOUT_OUT,
  output reg HRESP_OUT,
  // ROM read path
  input wire HSEL_ROM_IN,
  input wire [31:0] ROM_HRDATA_IN,
  output reg [31:0] ROM_HRDATA_OUT,
  // Enable flags, for observation
  output reg [7:0] ENTRY_ENABLE_OUT
);

  // Error response states
  localparam [1:0] ST_OKAY = 2'b00;
  localparam [1:0] ST_ERR_WAIT = 2'b01;
  localparam [1:0] ST_ERR_LAST = 2'b10;

  reg [31:0] entry_match_address [0:`RDPU_ENTRIES-1];
  reg [31:0] entry_replacement_data [0:`RDPU_ENTRIES-1];
  reg [7:0] entry_enable_flags;
  reg [7:0] address_written;

  // Register slave state
  reg [1:0] state;
  reg [1:0] next_state;
  reg wr_pend;
  reg [7:0] wr_idx;
  reg rom_hit;
  reg [31:0] rom_patch_word;
  // Next values of the registered paths
  reg [31:0] next_hrdata;
  reg [7:0] next_enable_flags;
  reg next_rom_hit;
  reg [31:0] next_rom_patch_word;

  wire [7:0] a_idx;
  wire a_in_window;
  wire a_mapped;
  wire reg_req;
  wire rom_rd_req;
  wire [3:0] match;
  integer i;

  // Highest enabled matching entry; bit 3 flags any hit
  function [3:0] pick_entry;
    input [31:0] addr;
    input [7:0] en;
    input [255:0] table_flat;
    integer k;
    begin
      pick_entry = 4'h0;
      // parallel compare, later entries override earlier ones
      for (k = 0; k < `RDPU_ENTRIES; k = k + 1) begin
        if (en[k] && (table_flat[k*32 +: 32] == addr)) begin
          pick_entry = {1'b1, k[2:0]};
        end
      end
    end
  endfunction

  // a word index below the flags register addresses one half of a pair
  function is_pair_word;
    input [7:0] idx;
    begin
      is_pair_word = (idx <= `RDPU_IDX_PAIR_LAST);
    end
  endfunction

  // Entry number of a pair word; the lowest index bit picks address or data
  function [2:0] pair_entry;
    input [7:0] idx;
    begin
      pair_entry = idx[`RDPU_PAIR_HI:`RDPU_PAIR_LO];
    end
  endfunction

  // High when a pair word addresses the replacement data half
  function is_data_half;
    input [7:0] idx;
    begin
      is_data_half = idx[`RDPU_PAIR_DATA_BIT];
    end
  endfunction

  // Flattened view of the address table for the comparator function
  wire [255:0] addr_flat;
  genvar g;
  generate
    for (g = 0; g < `RDPU_ENTRIES; g = g + 1) begin : g_flat
      assign addr_flat[g*32 +: 32] = entry_match_address[g];
    end
  endgenerate

  // window decode; the tag check guards against a loose select
  assign a_idx = HADDR_IN[`RDPU_WORD_HI:`RDPU_WORD_LO];
  assign a_in_window = (HADDR_IN[`RDPU_WIN_TAG_HI:`RDPU_WIN_TAG_LO] ==
                        `RDPU_WIN_TAG);
  // pairs fill words 0..15, then flags, disable and enable strobes
  assign a_mapped = a_in_window && (a_idx <= `RDPU_IDX_ENABLE);
  // address phase taken when selected, ready and transfer active
  assign reg_req = HSEL_REG_IN && HREADY_IN && HTRANS_IN[`RDPU_HTRANS_SEQ_BIT];
  // only ROM reads are candidates for substitution
  assign rom_rd_req = HSEL_ROM_IN && HREADY_IN && !HWRITE_IN &&
                      HTRANS_IN[`RDPU_HTRANS_SEQ_BIT];
  assign match = pick_entry(HADDR_IN, entry_enable_flags, addr_flat);

  // Error response sequencing: two-cycle ERROR for unmapped words
  always @* begin
    next_state = ST_OKAY;
    case (state)
      ST_OKAY: begin
        if (reg_req && !a_mapped) begin
          next_state = ST_ERR_WAIT;
        end
      end
      ST_ERR_WAIT: next_state = ST_ERR_LAST;
      ST_ERR_LAST: begin
        // Ready is high again here, so a new address phase may be taken
        if (reg_req && !a_mapped) begin
          next_state = ST_ERR_WAIT;
        end
      end
      default: next_state = ST_OKAY;
    endcase
  end

  // Slave handshake outputs follow the state register
  always @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      state <= ST_OKAY;
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT <= `RDPU_HRESP_OKAY;
    end else begin
      state <= next_state;
      HREADYOUT_OUT <= (next_state != ST_ERR_WAIT);
      HRESP_OUT <= (next_state == ST_OKAY) ? `RDPU_HRESP_OKAY : `RDPU_HRESP_ERROR;
    end
  end

  // Address phase capture for writes; data arrives a cycle later
  always @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      wr_pend <= 1'b0;
      wr_idx <= 8'h00;
    end else if (HREADY_IN) begin
      wr_pend <= reg_req && HWRITE_IN && a_mapped;
      wr_idx <= a_idx;
    end
  end

  // Register read mux, worked out in the address phase so the data phase
  // needs no wait state; write-only strobes and writes read as zero
  always @* begin
    next_hrdata = `RDPU_RST_WORD;
    if (a_mapped && !HWRITE_IN) begin
      if (is_pair_word(a_idx)) begin
        if (is_data_half(a_idx)) begin
          next_hrdata = entry_replacement_data[pair_entry(a_idx)];
        end else begin
          next_hrdata = entry_match_address[pair_entry(a_idx)];
        end
      end else if (a_idx == `RDPU_IDX_FLAGS) begin
        next_hrdata = {24'h000000, entry_enable_flags};
      end
    end
  end

  // Read data register; it holds until the next taken register transfer
  always @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      HRDATA_OUT <= `RDPU_RST_WORD;
    end else if (reg_req) begin
      HRDATA_OUT <= next_hrdata;
    end
  end

  // Enable flag update for the write completing in this data phase
  always @* begin
    next_enable_flags = entry_enable_flags;
    if (wr_pend && HREADY_IN) begin
      if (is_pair_word(wr_idx)) begin
        if (!is_data_half(wr_idx)) begin
          // a new address disarms its entry until the data word follows
          next_enable_flags[pair_entry(wr_idx)] = 1'b0;
        end else if (address_written[pair_entry(wr_idx)]) begin
          // enable set once both halves of the pair are written
          next_enable_flags[pair_entry(wr_idx)] = 1'b1;
        end
      end else if (wr_idx == `RDPU_IDX_DISABLE) begin
        // ones clear enables, zeros leave them
        next_enable_flags = entry_enable_flags & ~HWDATA_IN[7:0];
      end else if (wr_idx == `RDPU_IDX_ENABLE) begin
        next_enable_flags = entry_enable_flags | HWDATA_IN[7:0];
      end
    end
  end

  // table lost at reset
  // Entry table and enable flags, written in the data phase
  always @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      for (i = 0; i < `RDPU_ENTRIES; i = i + 1) begin
        entry_match_address[i] <= `RDPU_RST_WORD;
        entry_replacement_data[i] <= `RDPU_RST_WORD;
      end
      // no substitution until software programs entries
      entry_enable_flags <= `RDPU_RST_FLAGS;
      address_written <= `RDPU_RST_FLAGS;
    end else begin
      entry_enable_flags <= next_enable_flags;
      if (wr_pend && HREADY_IN && is_pair_word(wr_idx)) begin
        if (!is_data_half(wr_idx)) begin
          // address first; entry is parked until its data follows
          entry_match_address[pair_entry(wr_idx)] <= HWDATA_IN;
          address_written[pair_entry(wr_idx)] <= 1'b1;
        end else begin
          entry_replacement_data[pair_entry(wr_idx)] <= HWDATA_IN;
          // the data word uses up the arming of its pair
          address_written[pair_entry(wr_idx)] <= 1'b0;
        end
      end
    end
  end

  // Mirror of the enable flags for observation
  always @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      ENTRY_ENABLE_OUT <= `RDPU_RST_FLAGS;
    end else begin
      ENTRY_ENABLE_OUT <= entry_enable_flags;
    end
  end

  // capture the winning entry's replacement word, held while stalled
  always @* begin
    next_rom_hit = rom_hit;
    next_rom_patch_word = rom_patch_word;
    if (HREADY_IN) begin
      next_rom_hit = rom_rd_req && match[3];
      next_rom_patch_word = entry_replacement_data[match[2:0]];
    end
  end

  // Match decision taken in the ROM address phase
  always @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rom_hit <= 1'b0;
      rom_patch_word <= `RDPU_RST_WORD;
    end else begin
      rom_hit <= next_rom_hit;
      rom_patch_word <= next_rom_patch_word;
    end
  end

  // The ROM data mux must stay combinational on the ROM data: a register
  // here would cost every ROM read a wait state.
  always @* begin
    // pass ROM data unchanged, substitute on a hit
    ROM_HRDATA_OUT = rom_hit ? rom_patch_word : ROM_HRDATA_IN;
  end

  // HSIZE is not decoded: every access is treated as a full word
  wire unused_ok;
  assign unused_ok = &{1'b0, HSIZE_IN};

endmodule // rdpu_patch_unit
`default_nettype wire

// ### bench/rdpu_patch_unit_monitor.sv
// Port checker for the patch unit, bound to its top module.
// Assumes one clock domain and the active-low async reset.
`timescale 1ns/1ps
`default_nettype none
module rdpu_chk (
  input wire logic REF_CLK_IN,
  input wire logic RST_B_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  input wire logic HSEL_REG_IN,
  input wire logic [31:0] HRDATA_OUT,
  input wire logic HREADYOUT_OUT,
  input wire logic HRESP_OUT,
  input wire logic HSEL_ROM_IN,
  input wire logic [31:0] ROM_HRDATA_IN,
  input wire logic [31:0] ROM_HRDATA_OUT,
  input wire logic [7:0] ENTRY_ENABLE_OUT
);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  wire tk = HSEL_REG_IN && HREADY_IN && HTRANS_IN[1];
  wire inw = HADDR_IN[31:10] == 22'h100021;
  // Register write taken, then its data phase completes
  sequence s_wr(idx);
    tk && HWRITE_IN && inw && HADDR_IN[9:2] == idx ##1 HREADY_IN;
  endsequence
  chk_err_resp: assert property (tk && !inw |=> (!HREADYOUT_OUT && HRESP_OUT) ##1
    (HREADYOUT_OUT && HRESP_OUT)) else $error("two-cycle error missing");
  chk_okay_resp: assert property (tk && inw && HADDR_IN[9:2] <= 8'h12 |=>
    HREADYOUT_OUT && !HRESP_OUT) else $error("okay response missing");
  chk_flags_read: assert property (tk && inw && !HWRITE_IN && HADDR_IN[9:2] == 8'h10
    && !$past(HWRITE_IN) |=> HRDATA_OUT == {24'h0, ENTRY_ENABLE_OUT})
    else $error("flag read mismatch");
  chk_reset_flags: assert property ($rose(RST_B_IN) |->
    ENTRY_ENABLE_OUT == 8'h00) else $error("enables not cleared in reset");
  chk_disable_bits: assert property (s_wr(8'h11) |=> ##1
    (ENTRY_ENABLE_OUT & $past(HWDATA_IN[7:0], 2)) == 8'h00) else $error("disable failed");
  chk_enable_bits: assert property (s_wr(8'h12) |=> ##1
    (ENTRY_ENABLE_OUT & $past(HWDATA_IN[7:0], 2)) == $past(HWDATA_IN[7:0], 2))
    else $error("enable failed");
  chk_write_pass: assert property (HSEL_ROM_IN && HREADY_IN && HTRANS_IN[1] && HWRITE_IN
    |=> ROM_HRDATA_OUT == ROM_HRDATA_IN) else $error("write data patched");
  chk_idle_pass: assert property ((ENTRY_ENABLE_OUT == 8'h00)[*3] |->
    ROM_HRDATA_OUT == ROM_HRDATA_IN) else $error("data patched with no entry");
endmodule // rdpu_chk
bind rdpu_patch_unit rdpu_chk chk_u (.REF_CLK_IN(REF_CLK_IN), .RST_B_IN(RST_B_IN),
  .HADDR_IN(HADDR_IN), .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN), .HWDATA_IN(HWDATA_IN),
  .HREADY_IN(HREADY_IN), .HSEL_REG_IN(HSEL_REG_IN), .HRDATA_OUT(HRDATA_OUT),
  .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT), .HSEL_ROM_IN(HSEL_ROM_IN),
  .ROM_HRDATA_IN(ROM_HRDATA_IN), .ROM_HRDATA_OUT(ROM_HRDATA_OUT),
  .ENTRY_ENABLE_OUT(ENTRY_ENABLE_OUT));
`default_nettype wire

// ### bench/rdpu_rom_model.sv
// ROM controller read path: word at address a reads a ^ A5A5A5A5.
// Outside a data phase the data inverts every cycle, so stale use shows.
`timescale 1ns/1ps
`default_nettype none
module rdpu_rom_model (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hsel_in,
  output logic [31:0] rdata_out
);
  // Zero wait states; data appears in the cycle after the address
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) rdata_out <= 32'h0;
    else if (hsel_in && htrans_in[1] && !hwrite_in) rdata_out <= haddr_in ^ 32'hA5A5A5A5;
    else rdata_out <= ~rdata_out;
  end
endmodule // rdpu_rom_model
`default_nettype wire

// ### bench/rdpu_patch_unit_tb_top.sv
// Self-checking bench for the patch unit with a ROM path model.
// Assumes the unit's own ready is the bus ready (ROM adds no waits); one transfer at a time.
`timescale 1ns/1ps
`default_nettype none
module rdpu_patch_unit_tb_top;
  logic clk = 0, rst_b = 0, hwrite = 0, hsel_reg = 0, hsel_rom = 0, hresp, hrdy, e;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rom_in, rom_out, hrdata, r, ro, ri;
  logic [7:0] flags;
  int miscompares = 0, comparisons = 0;
  localparam logic [31:0] BASE = 32'h40008400, HIT = 32'h100, MISS = 32'h100 ^ 32'hA5A5A5A5;
  always #4 clk = ~clk;
  rdpu_rom_model rom_u (.clk_in(clk), .rst_b_in(rst_b), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsel_in(hsel_rom), .rdata_out(rom_in));
  rdpu_patch_unit dut_u (.REF_CLK_IN(clk), .RST_B_IN(rst_b), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
    .HREADY_IN(hrdy), .HSEL_REG_IN(hsel_reg), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hrdy),
    .HRESP_OUT(hresp), .HSEL_ROM_IN(hsel_rom), .ROM_HRDATA_IN(rom_in),
    .ROM_HRDATA_OUT(rom_out), .ENTRY_ENABLE_OUT(flags));
  task automatic chk(input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // One transfer to the registers or the ROM; error waits are bounded
  task automatic xfer(input logic to_rom, w, input logic [31:0] a, d);
    int n = 0;
    @(negedge clk);
    haddr = a;
    hwrite = w;
    htrans = 2'h2;
    hsel_reg = !to_rom;
    hsel_rom = to_rom;
    @(negedge clk);
    htrans = 2'h0;
    {hsel_reg, hsel_rom, hwrite} = 3'h0;
    hwdata = d;
    while (hrdy !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    if (hrdy !== 1'b1) begin
      miscompares++;
      $display("CHECK FAILED at %0t: no ready within 4 cycles", $time);
      complete_run;
    end else begin
      {r, e, ro, ri} = {hrdata, hresp, rom_out, rom_in};
    end
  endtask
  // nothing enabled after reset, ROM data passes
  task automatic t_reset;
    xfer(0, 0, BASE + 32'h40, 0);
    chk(r, 32'h0);
    xfer(1, 0, HIT, 0);
    chk(ro, MISS);
  endtask
  // every entry aims at one address, address written first
  task automatic t_program;
    for (int i = 0; i < 8; i++) begin
      xfer(0, 1, BASE + 8 * i, HIT);
      xfer(0, 1, BASE + 8 * i + 4, 32'hD0 + i);
      xfer(0, 0, BASE + 32'h40, 0);
      chk(r, (32'h2 << i) - 1);
      chk({24'h0, flags}, (32'h2 << i) - 1);
      xfer(0, 0, BASE + 8 * i, 0);
      chk(r, HIT);
      xfer(1, 0, HIT, 0);
      chk(ro, 32'hD0 + i);
    end
  endtask
  // drop the winner, drop all, then bring back the lowest
  task automatic t_toggle;
    xfer(0, 1, BASE + 32'h44, 32'h80);
    xfer(1, 0, HIT, 0);
    chk(ro, 32'hD6);
    xfer(0, 1, BASE + 32'h44, 32'h7F);
    xfer(1, 0, HIT, 0);
    chk(ro, MISS);
    xfer(0, 1, BASE + 32'h48, 32'h01);
    xfer(1, 0, HIT, 0);
    chk(ro, 32'hD0);
    xfer(1, 0, HIT + 32'h4, 0);
    chk(ro, (HIT + 32'h4) ^ 32'hA5A5A5A5);
    xfer(1, 1, HIT, 0);
    chk(ro, ri);
  endtask
  // outside the window, past the last register, read-only flags
  task automatic t_errors;
    xfer(0, 0, BASE + 32'h400, 0);
    chk({31'h0, e}, 32'h1);
    xfer(0, 0, BASE + 32'h4C, 0);
    chk({31'h0, e}, 32'h1);
    xfer(0, 1, BASE + 32'h40, 32'hFF);
    xfer(0, 0, BASE + 32'h40, 0);
    chk(r, 32'h01);
    chk({31'h0, e}, 32'h0);
  endtask
  initial begin
    repeat (3) @(negedge clk);
    rst_b = 1;
    t_reset;
    t_program;
    t_toggle;
    t_errors;
    // a second reset loses every entry
    rst_b = 0;
    @(negedge clk);
    rst_b = 1;
    t_reset;
    xfer(0, 0, BASE, 0);
    chk(r, 32'h0);
    complete_run;
  end
endmodule // rdpu_patch_unit_tb_top
`default_nettype wire
